// ===== hw/npr_cmd_core.sv
// Command core for nonce, pause and random commands
`timescale 1ns/1ps
`default_nettype none
module npr_cmd_core (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_mode,
  input wire logic [15:0] cmd_param2,
  input wire logic [5:0] cmd_len,
  input wire logic [255:0] host_input_value,
  output logic cmd_ready,
  input wire logic config_locked,
  input wire logic [7:0] selector_byte,
  input wire logic seed_update_needed,
  input wire logic seed_endurance_out,
  input wire logic seed_update_done,
  output logic seed_update_req,
  input wire logic [31:0] trng_bits,
  output logic sha_start,
  output logic [439:0] sha_msg,
  input wire logic sha_done,
  input wire logic [255:0] sha_digest,
  output logic rsp_valid,
  output logic [5:0] rsp_len,
  output logic [255:0] rsp_data,
  output logic enter_idle,
  output logic [255:0] scratch_digest_reg,
  output logic scratch_valid_flag,
  output logic scratch_origin_flag,
  output logic scratch_rw_ok
);

  npr_pkg::npr_state_t state_q;
  npr_pkg::npr_state_t state_d;
  logic [7:0] op_q;
  logic [7:0] op_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] p2lo_q;
  logic [7:0] p2lo_d;
  logic [159:0] in_q;
  logic [159:0] in_d;
  logic ready_q;
  logic ready_d;
  logic seed_req_q;
  logic seed_req_d;
  logic gen_req_q;
  logic gen_req_d;
  logic reseed_q;
  logic reseed_d;
  logic sha_start_q;
  logic sha_start_d;
  logic [439:0] msg_q;
  logic [439:0] msg_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [5:0] rsp_len_q;
  logic [5:0] rsp_len_d;
  logic [255:0] rsp_data_q;
  logic [255:0] rsp_data_d;
  logic idle_q;
  logic idle_d;
  logic [255:0] scratch_q;
  logic [255:0] scratch_d;
  logic valid_q;
  logic valid_d;
  logic origin_q;
  logic origin_d;
  logic rw_ok_q;
  logic rw_ok_d;
  logic is_nonce;
  logic is_pause;
  logic is_random;
  logic bad_cmd;
  logic pass_mode;

  npr_rng_if rif();

  // ----------------------------------------------------------------
  // Generator instance
  // ----------------------------------------------------------------
  npr_rng #(.WORDS(npr_pkg::RNG_WORDS)) u_rng (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .trng_bits(trng_bits),
    .rif(rif)
  );

  // Test pattern replaces entropy until configuration is locked
  assign rif.test_mode = ~config_locked;
  assign rif.gen_req = gen_req_q;
  assign rif.reseed = reseed_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Checks are made up front so an error never touches scratch state
  always_comb begin
    is_nonce = (cmd_opcode == npr_pkg::OP_NONCE);
    is_pause = (cmd_opcode == npr_pkg::OP_PAUSE);
    is_random = (cmd_opcode == npr_pkg::OP_RANDOM);
    pass_mode = (cmd_mode[1:0] == npr_pkg::NMODE_PASS);
    bad_cmd = (cmd_param2 != 16'h0000) || !(is_nonce || is_pause || is_random);
    if (is_nonce) begin
      if ((cmd_mode[7:2] != 6'h00) || (cmd_mode[1:0] == npr_pkg::NMODE_INVALID)) begin
        bad_cmd = 1'b1;
      end
      if (cmd_len != (pass_mode ? npr_pkg::LEN_PASS_IN : npr_pkg::LEN_HASHED_IN)) begin
        bad_cmd = 1'b1;
      end
    end
    if (is_random && ((cmd_mode[7:1] != 7'h00) || (cmd_len != npr_pkg::LEN_NONE))) begin
      bad_cmd = 1'b1;
    end
    if (is_pause && (cmd_len != npr_pkg::LEN_NONE)) begin
      bad_cmd = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    mode_d = mode_q;
    p2lo_d = p2lo_q;
    in_d = in_q;
    seed_req_d = 1'b0;
    gen_req_d = 1'b0;
    reseed_d = 1'b0;
    sha_start_d = 1'b0;
    msg_d = msg_q;
    rsp_valid_d = 1'b0;
    rsp_len_d = rsp_len_q;
    rsp_data_d = rsp_data_q;
    idle_d = 1'b0;
    scratch_d = scratch_q;
    valid_d = valid_q;
    origin_d = origin_q;
    case (state_q)
      npr_pkg::NPR_IDLE: begin
        if (cmd_valid) begin
          op_d = cmd_opcode;
          mode_d = cmd_mode;
          p2lo_d = cmd_param2[7:0];
          in_d = host_input_value[159:0];
          if (bad_cmd) begin
            rsp_valid_d = 1'b1;
            rsp_len_d = npr_pkg::LEN_RSP_BYTE;
            rsp_data_d = {248'h0, npr_pkg::ST_PARSE_ERR};
          end else if (is_pause) begin
            if (cmd_mode != selector_byte) begin
              idle_d = 1'b1; // Idle only, no sleep path exists
            end else begin
              rsp_valid_d = 1'b1;
              rsp_len_d = npr_pkg::LEN_RSP_BYTE;
              rsp_data_d = {248'h0, npr_pkg::ST_OK};
            end
          end else if (is_nonce && pass_mode) begin
            scratch_d = host_input_value;
            valid_d = 1'b1;
            origin_d = npr_pkg::ORIGIN_INPUT;
            rsp_valid_d = 1'b1;
            rsp_len_d = npr_pkg::LEN_RSP_BYTE;
            rsp_data_d = {248'h0, npr_pkg::ST_OK};
          end else if (!cmd_mode[0] && seed_update_needed) begin
            // Seed refresh only when mode bit zero is clear
            if (seed_endurance_out) begin
              rsp_valid_d = 1'b1;
              rsp_len_d = npr_pkg::LEN_RSP_BYTE;
              rsp_data_d = {248'h0, npr_pkg::ST_EXEC_ERR};
            end else begin
              seed_req_d = 1'b1;
              state_d = npr_pkg::NPR_SEED;
            end
          end else begin
            gen_req_d = 1'b1;
            state_d = npr_pkg::NPR_GEN;
          end
        end
      end
      npr_pkg::NPR_SEED: begin
        // Request held as a level until the store confirms
        seed_req_d = 1'b1;
        if (seed_update_done) begin
          seed_req_d = 1'b0;
          reseed_d = 1'b1;
          gen_req_d = 1'b1;
          state_d = npr_pkg::NPR_GEN;
        end
      end
      npr_pkg::NPR_GEN: begin
        if (rif.done) begin
          rsp_data_d = rif.rand_data;
          if (op_q == npr_pkg::OP_RANDOM) begin
            rsp_valid_d = 1'b1;
            rsp_len_d = npr_pkg::LEN_RSP_RAND;
            state_d = npr_pkg::NPR_IDLE;
          end else begin
            sha_start_d = 1'b1;
            msg_d = {p2lo_q, mode_q, npr_pkg::OP_NONCE, in_q, rif.rand_data};
            state_d = npr_pkg::NPR_HASH;
          end
        end
      end
      npr_pkg::NPR_HASH: begin
        if (sha_done) begin
          scratch_d = sha_digest;
          valid_d = 1'b1;
          origin_d = npr_pkg::ORIGIN_RAND;
          rsp_valid_d = 1'b1;
          rsp_len_d = npr_pkg::LEN_RSP_RAND; // Random value kept in rsp_data
          state_d = npr_pkg::NPR_IDLE;
        end
      end
      default: begin
        state_d = npr_pkg::NPR_IDLE;
      end
    endcase
    ready_d = (state_d == npr_pkg::NPR_IDLE);
    rw_ok_d = valid_d && (origin_d == npr_pkg::ORIGIN_RAND);
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= npr_pkg::NPR_IDLE;
      op_q <= 8'h00;
      mode_q <= 8'h00;
      p2lo_q <= 8'h00;
      in_q <= 160'h0;
      ready_q <= 1'b0;
      seed_req_q <= 1'b0;
      gen_req_q <= 1'b0;
      reseed_q <= 1'b0;
      sha_start_q <= 1'b0;
      msg_q <= 440'h0;
      rsp_valid_q <= 1'b0;
      rsp_len_q <= 6'h00;
      rsp_data_q <= 256'h0;
      idle_q <= 1'b0;
      scratch_q <= npr_pkg::SCRATCH_RESET;
      valid_q <= 1'b0;
      origin_q <= npr_pkg::ORIGIN_RAND;
      rw_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      mode_q <= mode_d;
      p2lo_q <= p2lo_d;
      in_q <= in_d;
      ready_q <= ready_d;
      seed_req_q <= seed_req_d;
      gen_req_q <= gen_req_d;
      reseed_q <= reseed_d;
      sha_start_q <= sha_start_d;
      msg_q <= msg_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_len_q <= rsp_len_d;
      rsp_data_q <= rsp_data_d;
      idle_q <= idle_d;
      scratch_q <= scratch_d;
      valid_q <= valid_d;
      origin_q <= origin_d;
      rw_ok_q <= rw_ok_d;
    end
  end

  // Outputs straight from flops
  assign cmd_ready = ready_q;
  assign seed_update_req = seed_req_q;
  assign sha_start = sha_start_q;
  assign sha_msg = msg_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_len = rsp_len_q;
  assign rsp_data = rsp_data_q;
  assign enter_idle = idle_q;
  assign scratch_digest_reg = scratch_q;
  assign scratch_valid_flag = valid_q;
  assign scratch_origin_flag = origin_q;
  assign scratch_rw_ok = rw_ok_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_take;
    state_q == npr_pkg::NPR_IDLE && cmd_valid && !bad_cmd;
  endsequence

  sequence s_pause_miss;
    s_take ##0 is_pause && (cmd_mode != selector_byte);
  endsequence

  property p_pause_miss;
    @(posedge sys_clk) disable iff (!resetn)
      s_pause_miss |=> enter_idle && !rsp_valid ##1 (!enter_idle || $past(cmd_valid));
  endproperty
  a_pause_miss: assert property (p_pause_miss) else $error("pause miss not idle");

  property p_pause_hit;
    @(posedge sys_clk) disable iff (!resetn)
      s_take ##0 is_pause && (cmd_mode == selector_byte) |=>
        rsp_valid && !enter_idle && rsp_len == 6'h01 && rsp_data[7:0] == 8'h00;
  endproperty
  a_pause_hit: assert property (p_pause_hit) else $error("pause hit bad answer");

  property p_pass;
    @(posedge sys_clk) disable iff (!resetn)
      s_take ##0 is_nonce && pass_mode |=> scratch_digest_reg == $past(host_input_value)
        && scratch_origin_flag && scratch_valid_flag && rsp_len == 6'h01
        && rsp_data[7:0] == 8'h00 && !scratch_rw_ok;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through load wrong");

  property p_hash_done;
    @(posedge sys_clk) disable iff (!resetn)
      state_q == npr_pkg::NPR_HASH && sha_done |=> scratch_digest_reg == $past(sha_digest)
        && scratch_valid_flag && !scratch_origin_flag && scratch_rw_ok
        && rsp_valid && rsp_len == 6'h20;
  endproperty
  a_hash_done: assert property (p_hash_done) else $error("hashed nonce wrong");

  property p_msg_fields;
    @(posedge sys_clk) disable iff (!resetn)
      sha_start |-> sha_msg[423:416] == 8'h16 && sha_msg[255:0] == rsp_data
        && sha_msg[431:424] == mode_q && sha_msg[439:432] == 8'h00;
  endproperty
  a_msg_fields: assert property (p_msg_fields) else $error("hash message fields wrong");

  property p_no_seed_mode1;
    @(posedge sys_clk) disable iff (!resetn)
      seed_update_req |-> !mode_q[0] && state_q == npr_pkg::NPR_SEED;
  endproperty
  a_no_seed_mode1: assert property (p_no_seed_mode1) else $error("mode one seeded");

  property p_endurance;
    @(posedge sys_clk) disable iff (!resetn)
      s_take ##0 !is_pause && !(is_nonce && pass_mode) && !cmd_mode[0]
        && seed_update_needed && seed_endurance_out |=>
        rsp_valid && rsp_data[7:0] == 8'h0f && !seed_update_req ##1 !gen_req_q;
  endproperty
  a_endurance: assert property (p_endurance) else $error("exhausted seed not refused");

  property p_random_rsp;
    @(posedge sys_clk) disable iff (!resetn)
      state_q == npr_pkg::NPR_GEN && rif.done && op_q == npr_pkg::OP_RANDOM |=>
        rsp_valid && rsp_len == 6'h20 && rsp_data == $past(rif.rand_data) && !sha_start;
  endproperty
  a_random_rsp: assert property (p_random_rsp) else $error("random answer wrong");

  property p_test_pattern;
    @(posedge sys_clk) disable iff (!resetn)
      rif.done && $past(!config_locked, 1) && $past(!config_locked, 8) |->
        rif.rand_data == {8{32'h0000ffff}};
  endproperty
  a_test_pattern: assert property (p_test_pattern) else $error("test pattern missing");

  property p_bad_len;
    @(posedge sys_clk) disable iff (!resetn)
      state_q == npr_pkg::NPR_IDLE && cmd_valid && bad_cmd |=>
        rsp_valid && rsp_data[7:0] == 8'h03 && state_q == npr_pkg::NPR_IDLE;
  endproperty
  a_bad_len: assert property (p_bad_len) else $error("bad command not refused");

endmodule
`default_nettype wire

// ===== pkg/npr_pkg.sv
// Shared constants for the nonce, pause and random command block
package npr_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PAUSE = 8'h01;
  localparam logic [7:0] OP_NONCE = 8'h16;
  localparam logic [7:0] OP_RANDOM = 8'h1b;

  // ----------------------------------------------------------------
  // Lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_HASHED_IN = 6'h14;
  localparam logic [5:0] LEN_PASS_IN = 6'h20;
  localparam logic [5:0] LEN_NONE = 6'h00;
  localparam logic [5:0] LEN_RSP_BYTE = 6'h01;
  localparam logic [5:0] LEN_RSP_RAND = 6'h20;

  // ----------------------------------------------------------------
  // Nonce mode field
  // ----------------------------------------------------------------
  localparam logic [1:0] NMODE_INVALID = 2'h2;
  localparam logic [1:0] NMODE_PASS = 2'h3;

  // ----------------------------------------------------------------
  // Status codes carried in the single response byte
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_PARSE_ERR = 8'h03;
  localparam logic [7:0] ST_EXEC_ERR = 8'h0f;

  // ----------------------------------------------------------------
  // Generator, flags and reset values
  // ----------------------------------------------------------------
  localparam int RNG_WORDS = 8;
  localparam logic [31:0] TEST_WORD = 32'h0000ffff;
  localparam logic ORIGIN_RAND = 1'h0;
  localparam logic ORIGIN_INPUT = 1'h1;
  localparam logic [255:0] SEED_RESET = 256'h0;
  localparam logic [255:0] SCRATCH_RESET = 256'h0;
  localparam int MSG_OPCODE_LSB = 416;

  typedef enum {
    NPR_IDLE,
    NPR_SEED,
    NPR_GEN,
    NPR_HASH
  } npr_state_t;

endpackage

// ===== pkg/npr_rng_if.sv
// Link between the command core and the random generator
`timescale 1ns/1ps
`default_nettype none
interface npr_rng_if;
  logic gen_req;
  logic reseed;
  logic test_mode;
  logic done;
  logic [255:0] rand_data;

  modport core (output gen_req, output reseed, output test_mode, input done, input rand_data);
  modport gen (input gen_req, input reseed, input test_mode, output done, output rand_data);
endinterface
`default_nettype wire

// ===== hw/npr_rng.sv
// Random generator: hardware entropy mixed with an internal seed
`timescale 1ns/1ps
`default_nettype none
module npr_rng #(
  parameter int WORDS = npr_pkg::RNG_WORDS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [31:0] trng_bits,
  npr_rng_if.gen rif
);

  logic [255:0] seed_q;
  logic [255:0] seed_d;
  logic [255:0] data_q;
  logic [255:0] data_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic [31:0] word;

  // ----------------------------------------------------------------
  // Word generation
  // ----------------------------------------------------------------
  // One seed serves every command, so nonce and random share state
  always_comb begin
    seed_d = seed_q;
    data_d = data_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    word = rif.test_mode ? npr_pkg::TEST_WORD : (trng_bits ^ seed_q[31:0]);
    if (!busy_q) begin
      if (rif.gen_req) begin
        busy_d = 1'b1;
        cnt_d = 4'h0;
        if (rif.reseed) begin
          seed_d = seed_q ^ {8{trng_bits}}; // Fresh seed after update
        end
      end
    end else begin
      // Shift in at the top so word 0 lands in bytes 0..3
      data_d = {word, data_q[255:32]};
      // Seed evolves every word so no two draws repeat the mix
      seed_d = {seed_q[31:0] ^ {trng_bits[15:0], trng_bits[31:16]}, seed_q[255:32]};
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == 4'(WORDS - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      seed_q <= npr_pkg::SEED_RESET;
      data_q <= 256'h0;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      seed_q <= seed_d;
      data_q <= data_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign rif.done = done_q;
  assign rif.rand_data = data_q;

endmodule
`default_nettype wire

// ===== verification/npr_far_model.sv
// Behavioural model of the seed store and hash engine beside the command core
`timescale 1ns/1ps
`default_nettype none
module npr_far_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic seed_update_req,
  input wire logic sha_start,
  input wire logic [439:0] sha_msg,
  output logic seed_update_done = 1'b0,
  output logic sha_done = 1'b0,
  output logic [255:0] sha_digest
);
  logic [3:0] seed_cnt_q = 4'h0;
  logic [3:0] sha_cnt_q = 4'h0;
  logic seed_busy_q = 1'b0;
  logic sha_busy_q = 1'b0;
  logic [255:0] dig_q = 256'h0;

  // ----------------------------------------------------------------
  // Digest bus
  // ----------------------------------------------------------------
  // Only meaningful with the done pulse; otherwise show the inverse
  assign sha_digest = sha_done ? dig_q : ~dig_q;

  // ----------------------------------------------------------------
  // Request servicing
  // ----------------------------------------------------------------
  // Seed request seen while done is still high was already served: one pulse each
  always @(posedge sys_clk) begin
    seed_update_done <= 1'b0;
    sha_done <= 1'b0;
    if (!resetn) begin
      seed_busy_q <= 1'b0;
      sha_busy_q <= 1'b0;
    end else begin
      if (seed_busy_q) begin
        seed_cnt_q <= seed_cnt_q - 4'h1;
        if (seed_cnt_q == 4'h0) begin
          seed_busy_q <= 1'b0;
          seed_update_done <= 1'b1;
        end
      end else if (seed_update_req && !seed_update_done) begin
        seed_busy_q <= 1'b1;
        seed_cnt_q <= slow ? 4'h9 : 4'h0;
      end
      if (sha_busy_q) begin
        sha_cnt_q <= sha_cnt_q - 4'h1;
        if (sha_cnt_q == 4'h0) begin
          sha_busy_q <= 1'b0;
          sha_done <= 1'b1;
        end
      end else if (sha_start) begin
        sha_busy_q <= 1'b1;
        sha_cnt_q <= slow ? 4'h8 : 4'h0;
        dig_q <= ~sha_msg[255:0]; // Stand-in hash, cheap to predict
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/nonce_pause_random_cmds_tb_top.sv
// Self-checking bench for the nonce, pause and random command core
`timescale 1ns/1ps
`default_nettype none
module nonce_pause_random_cmds_tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_opcode = 8'h00;
  logic [7:0] cmd_mode = 8'h00;
  logic [15:0] cmd_param2 = 16'h0000;
  logic [5:0] cmd_len = 6'h00;
  logic [255:0] host_input_value = 256'h0;
  logic config_locked = 1'b0;
  logic [7:0] selector_byte = 8'h5a;
  logic seed_update_needed = 1'b0;
  logic seed_endurance_out = 1'b0;
  logic slow = 1'b0;
  logic [31:0] trng_bits = 32'h0;
  logic cmd_ready, seed_update_req, seed_update_done, sha_start, sha_done, rsp_valid, enter_idle;
  logic [439:0] sha_msg;
  logic [255:0] sha_digest, rsp_data, scratch_digest_reg;
  logic [5:0] rsp_len;
  logic scratch_valid_flag, scratch_origin_flag, scratch_rw_ok;
  logic saw_rsp = 1'b0;
  logic saw_idle = 1'b0;
  logic saw_seed = 1'b0;
  logic [439:0] cap_msg = 440'h0;
  logic [255:0] exp_scr = 256'h0;
  logic [31:0] rng_q = 32'h96f14d26;
  logic [31:0] trng_q = 32'h96f14d26;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Malformed commands: mode two, reserved bit, wrong length, param two, opcode
  logic [7:0] e_op [7] = '{8'h16, 8'h16, 8'h16, 8'h1b, 8'h1b, 8'h55, 8'h01};
  logic [7:0] e_md [7] = '{8'h02, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00, 8'h5a};
  logic [15:0] e_p2 [7] = '{16'h0, 16'h0, 16'h0, 16'h0001, 16'h0, 16'h0, 16'h0};
  logic [5:0] e_ln [7] = '{6'h14, 6'h14, 6'h20, 6'h00, 6'h00, 6'h00, 6'h01};

  initial forever #2 sys_clk = ~sys_clk;

  npr_cmd_core uut (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_mode(cmd_mode), .cmd_param2(cmd_param2), .cmd_len(cmd_len),
    .host_input_value(host_input_value), .cmd_ready(cmd_ready), .config_locked(config_locked),
    .selector_byte(selector_byte), .seed_update_needed(seed_update_needed),
    .seed_endurance_out(seed_endurance_out), .seed_update_done(seed_update_done),
    .seed_update_req(seed_update_req), .trng_bits(trng_bits), .sha_start(sha_start),
    .sha_msg(sha_msg), .sha_done(sha_done), .sha_digest(sha_digest), .rsp_valid(rsp_valid),
    .rsp_len(rsp_len), .rsp_data(rsp_data), .enter_idle(enter_idle),
    .scratch_digest_reg(scratch_digest_reg), .scratch_valid_flag(scratch_valid_flag),
    .scratch_origin_flag(scratch_origin_flag), .scratch_rw_ok(scratch_rw_ok)
  );

  npr_far_model far (
    .sys_clk(sys_clk), .resetn(resetn), .slow(slow), .seed_update_req(seed_update_req),
    .sha_start(sha_start), .sha_msg(sha_msg), .seed_update_done(seed_update_done),
    .sha_done(sha_done), .sha_digest(sha_digest)
  );

  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Unlocked generator output: bytes FF FF 00 00 repeating
  function automatic logic [255:0] pat();
    logic [255:0] p;
    for (int k = 0; k < 32; k++) begin
      p[8*k +: 8] = (k % 4 < 2) ? 8'hff : 8'h00;
    end
    return p;
  endfunction

  // Hash message: random, 20 input bytes, opcode, mode, low byte of param two
  function automatic logic [439:0] exp_msg(input logic [7:0] md, input logic [255:0] din);
    return {8'h00, md, 8'h16, din[159:0], pat()};
  endfunction

  task automatic rnd256(output logic [255:0] v);
    for (int k = 0; k < 8; k++) begin
      rng_q = xorshift(rng_q);
      v[32*k +: 32] = rng_q;
    end
  endtask

  // ----------------------------------------------------------------
  // Monitors, entropy and hang guard
  // ----------------------------------------------------------------
  // Pulses last one cycle, so latch them here rather than poll
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rsp_valid === 1'b1) saw_rsp <= 1'b1;
    if (enter_idle === 1'b1) saw_idle <= 1'b1;
    if (seed_update_req === 1'b1) saw_seed <= 1'b1;
    if (sha_start === 1'b1) cap_msg <= sha_msg;
    if (cyc == 30000) begin
      num_errors++;
      give_verdict();
    end
  end

  always @(negedge sys_clk) begin
    trng_q <= xorshift(trng_q);
    trng_bits <= trng_q;
  end

  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t ns: %s", $time, what);
    end
  endtask

  task automatic chk_byte(input logic [7:0] st, input string what);
    chk(saw_rsp === 1'b1 && rsp_len === 6'h01 && rsp_data[7:0] === st, what);
  endtask

  // One command, offered at a falling edge once ready, then wait for its answer
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] md, input logic [15:0] p2,
                         input logic [5:0] ln, input logic [255:0] din);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    saw_rsp = 1'b0;
    saw_idle = 1'b0;
    saw_seed = 1'b0;
    cap_msg = 440'h0;
    cmd_opcode = op;
    cmd_mode = md;
    cmd_param2 = p2;
    cmd_len = ln;
    host_input_value = din;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!saw_rsp && !saw_idle && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 3000, "no answer to command");
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [255:0] din;
    logic [439:0] msg;
    logic [255:0] first;
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk(scratch_valid_flag === 1'b0 && scratch_digest_reg === 256'h0, "scratch after reset");
    run_cmd(npr_pkg::OP_PAUSE, 8'ha5, 16'h0, 6'h0, 256'h0);
    repeat (2) @(negedge sys_clk);
    chk(saw_idle === 1'b1 && saw_rsp === 1'b0, "pause mismatch");
    run_cmd(npr_pkg::OP_PAUSE, 8'h5a, 16'h0, 6'h0, 256'h0);
    chk_byte(8'h00, "pause match answer");
    chk(saw_idle === 1'b0, "pause match stayed active");
    $display("test pause done");
    // Seed wants refresh; mode one must leave it alone
    seed_update_needed = 1'b1;
    run_cmd(npr_pkg::OP_RANDOM, 8'h01, 16'h0, 6'h0, 256'h0);
    chk(rsp_len === 6'h20 && rsp_data === pat(), "random test pattern");
    chk(saw_seed === 1'b0, "random mode one kept seed");
    slow = 1'b1;
    run_cmd(npr_pkg::OP_RANDOM, 8'h00, 16'h0, 6'h0, 256'h0);
    chk(saw_seed === 1'b1 && rsp_data === pat(), "random refresh");
    $display("test random done");
    for (int m = 0; m < 2; m++) begin
      rnd256(din);
      run_cmd(npr_pkg::OP_NONCE, 8'(m), 16'h0, 6'h14, din);
      msg = exp_msg(8'(m), din);
      exp_scr = ~msg[255:0];
      chk(cap_msg === msg, "nonce hash message");
      chk(rsp_len === 6'h20 && rsp_data === pat(), "nonce answer");
      chk(scratch_digest_reg === exp_scr && scratch_valid_flag === 1'b1, "scratch");
      chk(scratch_origin_flag === 1'b0 && scratch_rw_ok === 1'b1, "nonce origin");
      chk(saw_seed === (m == 0), "nonce seed refresh");
    end
    $display("test hashed nonce done");
    // Worn-out seed store: only requests that would refresh are refused
    seed_endurance_out = 1'b1;
    run_cmd(npr_pkg::OP_RANDOM, 8'h00, 16'h0, 6'h0, 256'h0);
    chk_byte(npr_pkg::ST_EXEC_ERR, "random on worn seed");
    run_cmd(npr_pkg::OP_NONCE, 8'h00, 16'h0, 6'h14, din);
    chk_byte(npr_pkg::ST_EXEC_ERR, "nonce on worn seed");
    chk(scratch_digest_reg === exp_scr, "scratch kept on error");
    run_cmd(npr_pkg::OP_NONCE, 8'h01, 16'h0, 6'h14, din);
    chk(rsp_len === 6'h20 && saw_seed === 1'b0, "nonce mode one on worn seed");
    msg = exp_msg(8'h01, din);
    exp_scr = ~msg[255:0];
    seed_endurance_out = 1'b0;
    seed_update_needed = 1'b0;
    slow = 1'b0;
    $display("test endurance done");
    for (int i = 0; i < 7; i++) begin
      run_cmd(e_op[i], e_md[i], e_p2[i], e_ln[i], din);
      chk_byte(npr_pkg::ST_PARSE_ERR, "malformed command");
      chk(scratch_digest_reg === exp_scr, "scratch kept");
    end
    $display("test malformed done");
    config_locked = 1'b1;
    for (int i = 0; i < 12; i++) begin
      rnd256(din);
      if (din[0]) begin
        run_cmd(npr_pkg::OP_NONCE, 8'h03, 16'h0, 6'h20, din);
        exp_scr = din;
        chk_byte(8'h00, "pass-through answer");
        chk(scratch_origin_flag === 1'b1 && scratch_rw_ok === 1'b0, "pass flags");
      end else begin
        run_cmd(npr_pkg::OP_NONCE, {din[15:10] | 6'h01, 2'h3}, din[31:16], 6'h20, din);
        chk_byte(npr_pkg::ST_PARSE_ERR, "reserved mode bits");
      end
      chk(scratch_digest_reg === exp_scr, "scratch contents");
    end
    $display("test pass-through done");
    // Locked part: real entropy, so the second draw must differ from the first and avoid the pattern
    run_cmd(npr_pkg::OP_RANDOM, 8'h00, 16'h0, 6'h0, 256'h0);
    chk(saw_seed === 1'b0, "no refresh when not needed");
    first = rsp_data;
    run_cmd(npr_pkg::OP_RANDOM, 8'h01, 16'h0, 6'h0, 256'h0);
    chk(rsp_len === 6'h20 && rsp_data !== pat() && rsp_data !== first, "locked random");
    $display("test locked random done");
    give_verdict();
  end
endmodule
`default_nettype wire
